/* core/wkp_regs.sv */
// module: wake pattern 2 and 3 mask and crc registers with their matchers

// Summary of operation
// - first mask bit 0 picks pattern byte 1, bit 15 picks byte 16.
// - second mask bits 0..15 pick pattern bytes 17..32 in order.
// - third mask bits 0..15 pick pattern bytes 33..48 in order.
// - fourth mask bits 0..15 pick bytes 49..64; bytes past 64 never used.
// - check value is ethernet crc-32 over masked frame bytes only.
// - pattern 3 crc kept as low half then high half registers.
// - pattern 3 high crc half is host read/write and feeds the compare.
// - pattern 2 crc low and high halves are read/write, reset to zero.
module wkp_regs (
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [1:0]  i_reg_be,
  input  wire logic [15:0] i_reg_wdata,
  output logic      [15:0] o_reg_rdata,
  output logic             o_reg_rvalid,
  output logic             o_reg_hit,
  input  wire logic [15:0] i_pat2_mask_b1_16,
  input  wire logic        i_rx_valid,
  input  wire logic        i_rx_sof,
  input  wire logic        i_rx_eof,
  input  wire logic [7:0]  i_rx_data,
  output logic             o_pat2_match,
  output logic             o_pat3_match
);

  // ***************************************************************
  // reset release
  // ***************************************************************
  logic rst_meta_r;
  logic rst_n_r;

  // assert at once, release two edges later so no flop sees a runt
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ***************************************************************
  // register storage
  // ***************************************************************
  logic [15:0] regs_r [wkp_regs_pkg::REG_NUM];
  logic [3:0]  acc_idx;
  logic        acc_hit;

  // decode is shared by write and read, address bit 0 ignored so an odd byte address hits its even word
  always_comb begin
    acc_idx = wkp_regs_pkg::addr_to_idx(i_reg_addr);
    acc_hit = (acc_idx != wkp_regs_pkg::IDX_NONE);
  end

  // both crc halves of pattern 3 sit in their own slots
  // pattern 2 crc halves reset to zero and take host writes
  always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      for (int i = 0; i < wkp_regs_pkg::REG_NUM; i++) begin
        regs_r[i] <= wkp_regs_pkg::REG_RESET;
      end
    end else if (i_reg_wr && acc_hit) begin
      regs_r[acc_idx] <= wkp_regs_pkg::be_merge(regs_r[acc_idx], i_reg_wdata, i_reg_be);
    end
  end

  // ***************************************************************
  // host read path
  // ***************************************************************
  // read data is registered; a read beside a write returns the old word
  always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_reg_rdata  <= wkp_regs_pkg::RDATA_UNMAPPED;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        // high crc half reads back as written
        o_reg_rdata <= acc_hit ? regs_r[acc_idx] : wkp_regs_pkg::RDATA_UNMAPPED;
      end
    end
  end

  // decode flag only, host may use it to steer its own mux
  assign o_reg_hit = acc_hit && (i_reg_wr || i_reg_rd);

  // ***************************************************************
  // pattern windows and expected values
  // ***************************************************************
  logic [63:0] pat2_mask;
  logic [63:0] pat3_mask;
  logic [31:0] pat2_crc_exp;
  logic [31:0] pat3_crc_exp;

  // mask word 0 is bytes 1..16, bit 0 first
  // word 3 is bytes 49..64, top of the window
  always_comb begin
    pat2_mask = {regs_r[wkp_regs_pkg::IDX_PAT2_MASK_B49_64],
                 regs_r[wkp_regs_pkg::IDX_PAT2_MASK_B33_48],
                 regs_r[wkp_regs_pkg::IDX_PAT2_MASK_B17_32],
                 i_pat2_mask_b1_16};
    pat3_mask = {regs_r[wkp_regs_pkg::IDX_PAT3_MASK_B49_64],
                 regs_r[wkp_regs_pkg::IDX_PAT3_MASK_B33_48],
                 regs_r[wkp_regs_pkg::IDX_PAT3_MASK_B17_32],
                 regs_r[wkp_regs_pkg::IDX_PAT3_MASK_B1_16]};
  end

  // low address half is crc bits 15:0
  // high half supplies crc bits 31:16 of the compare
  always_comb begin
    pat2_crc_exp = {regs_r[wkp_regs_pkg::IDX_PAT2_CRC_HIGH],
                    regs_r[wkp_regs_pkg::IDX_PAT2_CRC_LOW]};
    pat3_crc_exp = {regs_r[wkp_regs_pkg::IDX_PAT3_CRC_HIGH],
                    regs_r[wkp_regs_pkg::IDX_PAT3_CRC_LOW]};
  end

  // ***************************************************************
  // matchers
  // ***************************************************************
  wkp_rx_if rx_bus ();

  // same-clock stream from the mac receive path, no synchroniser
  assign rx_bus.valid = i_rx_valid;
  assign rx_bus.sof   = i_rx_sof;
  assign rx_bus.eof   = i_rx_eof;
  assign rx_bus.data  = i_rx_data;

  // pattern 2 compare against its full 32-bit value
  wkp_matcher #(
    .NBYTES (wkp_regs_pkg::PAT_BYTES)
  ) u_pat2 (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (rst_n_r),
    .rx        (rx_bus.snk),
    .i_mask    (pat2_mask),
    .i_crc_exp (pat2_crc_exp),
    .o_match   (o_pat2_match)
  );

  // pattern 3 compare against its full 32-bit value
  wkp_matcher #(
    .NBYTES (wkp_regs_pkg::PAT_BYTES)
  ) u_pat3 (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (rst_n_r),
    .rx        (rx_bus.snk),
    .i_mask    (pat3_mask),
    .i_crc_exp (pat3_crc_exp),
    .o_match   (o_pat3_match)
  );

endmodule : wkp_regs

/* core/wkp_regs_pkg.sv */
// package: offsets, indices, reset values and crc helpers of the wake pattern bank
package wkp_regs_pkg;

  // ***************************************************************
  // register map (byte addresses on the 16-bit host bus)
  // ***************************************************************
  localparam logic [7:0] OFF_PAT2_CRC_LOW      = 8'h50;
  localparam logic [7:0] OFF_PAT2_CRC_HIGH     = 8'h52;
  localparam logic [7:0] OFF_PAT2_MASK_B17_32  = 8'h56;
  localparam logic [7:0] OFF_PAT2_MASK_B33_48  = 8'h58;
  localparam logic [7:0] OFF_PAT2_MASK_B49_64  = 8'h5a;
  localparam logic [7:0] OFF_PAT3_CRC_LOW      = 8'h60;
  localparam logic [7:0] OFF_PAT3_CRC_HIGH     = 8'h62;
  localparam logic [7:0] OFF_PAT3_MASK_B1_16   = 8'h64;
  localparam logic [7:0] OFF_PAT3_MASK_B17_32  = 8'h66;
  localparam logic [7:0] OFF_PAT3_MASK_B33_48  = 8'h68;
  localparam logic [7:0] OFF_PAT3_MASK_B49_64  = 8'h6a;

  // ***************************************************************
  // storage slots
  // ***************************************************************
  localparam int         REG_NUM               = 11;
  localparam logic [3:0] IDX_PAT2_CRC_LOW      = 4'h0;
  localparam logic [3:0] IDX_PAT2_CRC_HIGH     = 4'h1;
  localparam logic [3:0] IDX_PAT2_MASK_B17_32  = 4'h2;
  localparam logic [3:0] IDX_PAT2_MASK_B33_48  = 4'h3;
  localparam logic [3:0] IDX_PAT2_MASK_B49_64  = 4'h4;
  localparam logic [3:0] IDX_PAT3_CRC_LOW      = 4'h5;
  localparam logic [3:0] IDX_PAT3_CRC_HIGH     = 4'h6;
  localparam logic [3:0] IDX_PAT3_MASK_B1_16   = 4'h7;
  localparam logic [3:0] IDX_PAT3_MASK_B17_32  = 4'h8;
  localparam logic [3:0] IDX_PAT3_MASK_B33_48  = 4'h9;
  localparam logic [3:0] IDX_PAT3_MASK_B49_64  = 4'ha;
  localparam logic [3:0] IDX_NONE              = 4'hf;

  localparam logic [15:0] REG_RESET            = 16'h0000;
  localparam logic [15:0] RDATA_UNMAPPED       = 16'h0000;

  // ***************************************************************
  // pattern window and crc
  // ***************************************************************
  localparam int          PAT_BYTES            = 64;
  localparam logic [31:0] CRC_INIT             = 32'hffffffff;
  localparam logic [31:0] CRC_XOROUT           = 32'hffffffff;
  localparam logic [31:0] CRC_POLY_REFL        = 32'hedb88320;

  // map a bus address to a storage slot, IDX_NONE when unmapped
  function automatic logic [3:0] addr_to_idx(input logic [7:0] addr);
    logic [7:0] a;
    a = {addr[7:1], 1'b0};
    unique case (a)
      OFF_PAT2_CRC_LOW:     addr_to_idx = IDX_PAT2_CRC_LOW;
      OFF_PAT2_CRC_HIGH:    addr_to_idx = IDX_PAT2_CRC_HIGH;
      OFF_PAT2_MASK_B17_32: addr_to_idx = IDX_PAT2_MASK_B17_32;
      OFF_PAT2_MASK_B33_48: addr_to_idx = IDX_PAT2_MASK_B33_48;
      OFF_PAT2_MASK_B49_64: addr_to_idx = IDX_PAT2_MASK_B49_64;
      OFF_PAT3_CRC_LOW:     addr_to_idx = IDX_PAT3_CRC_LOW;
      OFF_PAT3_CRC_HIGH:    addr_to_idx = IDX_PAT3_CRC_HIGH;
      OFF_PAT3_MASK_B1_16:  addr_to_idx = IDX_PAT3_MASK_B1_16;
      OFF_PAT3_MASK_B17_32: addr_to_idx = IDX_PAT3_MASK_B17_32;
      OFF_PAT3_MASK_B33_48: addr_to_idx = IDX_PAT3_MASK_B33_48;
      OFF_PAT3_MASK_B49_64: addr_to_idx = IDX_PAT3_MASK_B49_64;
      default:              addr_to_idx = IDX_NONE;
    endcase
  endfunction : addr_to_idx

  // merge write data into a word under byte enables
  function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [15:0] wd,
                                           input logic [1:0] be);
    be_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : be_merge

  // one byte of the reflected ethernet crc, lsb of the byte first
  function automatic logic [31:0] crc_byte(input logic [31:0] crc, input logic [7:0] d);
    logic [31:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ d[i]) begin
        c = (c >> 1) ^ CRC_POLY_REFL;
      end else begin
        c = c >> 1;
      end
    end
    crc_byte = c;
  endfunction : crc_byte

endpackage : wkp_regs_pkg

/* core/wkp_rx_if.sv */
// interface: received byte stream shared by the pattern matchers
interface wkp_rx_if;
  logic       valid;
  logic       sof;
  logic       eof;
  logic [7:0] data;

  modport src (output valid, output sof, output eof, output data);
  modport snk (input valid, input sof, input eof, input data);
endinterface : wkp_rx_if

/* core/wkp_matcher.sv */
// module: crc over masked frame bytes and compare with the expected value
module wkp_matcher #(
  parameter int NBYTES = wkp_regs_pkg::PAT_BYTES
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  wkp_rx_if.snk                  rx,
  input  wire logic [NBYTES-1:0] i_mask,
  input  wire logic [31:0]       i_crc_exp,
  output logic                   o_match
);

  typedef enum logic [1:0] {
    WKPM_IDLE = 2'b01,
    WKPM_RUN  = 2'b10
  } wkpm_state_t;

  wkpm_state_t state_r;
  logic [6:0]  cnt_r;
  logic [31:0] crc_r;
  logic        take;
  logic [6:0]  cnt_cur;
  logic [31:0] crc_cur;
  logic [31:0] crc_nxt;
  logic        sel;

  // ***************************************************************
  // byte selection and crc step
  // ***************************************************************
  // a sof byte restarts the window even inside a frame that lost its eof
  always_comb begin
    take    = rx.valid && (rx.sof || (state_r == WKPM_RUN));
    cnt_cur = rx.sof ? 7'h00 : cnt_r;
    crc_cur = rx.sof ? wkp_regs_pkg::CRC_INIT : crc_r;
    sel     = take && (cnt_cur < 7'(NBYTES)) && i_mask[cnt_cur[5:0]];
    crc_nxt = sel ? wkp_regs_pkg::crc_byte(crc_cur, rx.data) : crc_cur;
  end

  // frame tracking
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= WKPM_IDLE;
    end else if (take) begin
      state_r <= rx.eof ? WKPM_IDLE : WKPM_RUN;
    end
  end

  // byte position, saturates past the window
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= 7'h00;
      crc_r <= wkp_regs_pkg::CRC_INIT;
    end else if (take) begin
      cnt_r <= (cnt_cur < 7'(NBYTES)) ? cnt_cur + 7'h01 : cnt_cur;
      crc_r <= crc_nxt;
    end
  end

  // one-cycle match pulse after the eof byte; an empty mask never matches
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_match <= 1'b0;
    end else begin
      o_match <= take && rx.eof && (|i_mask)
                 && ((crc_nxt ^ wkp_regs_pkg::CRC_XOROUT) == i_crc_exp);
    end
  end

endmodule : wkp_matcher

/* verif/wkp_regs_checker.sv */
// checker: port-level assertions of the wake pattern register bank
module wkp_regs_checker (
  input wire logic        i_sys_clk,
  input wire logic        i_nrst,
  input wire logic [7:0]  i_reg_addr,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [1:0]  i_reg_be,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] o_reg_rdata,
  input wire logic        o_reg_rvalid,
  input wire logic        o_reg_hit,
  input wire logic        i_rx_valid,
  input wire logic        i_rx_eof,
  input wire logic        o_pat2_match,
  input wire logic        o_pat3_match
);
  timeunit 1ns;
  timeprecision 1ps;
  // ***************************************************************
  // host side
  // ***************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  chk_rd_answer: assert property (i_reg_rd |=> o_reg_rvalid) else $error("no rvalid");
  chk_rvalid_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd)) else $error("rvalid");
  chk_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata)) else $error("rdata");
  chk_hole_zero: assert property (i_reg_rd && i_reg_addr[7:2] == 6'h17 |=>
    o_reg_rdata == 16'h0000) else $error("hole data");
  chk_hole_nohit: assert property ((i_reg_rd || i_reg_wr) && i_reg_addr[7:2] == 6'h17
    |-> !o_reg_hit) else $error("hole hit");
  chk_high_hit: assert property ((i_reg_rd || i_reg_wr) && i_reg_addr[7:1] == 7'h31
    |-> o_reg_hit) else $error("high hit");
  chk_high_wr_rd: assert property (i_reg_wr && i_reg_be == 2'h3 && i_reg_addr[7:1] == 7'h31
    ##1 !i_reg_wr ##1 (i_reg_rd && !i_reg_wr && i_reg_addr[7:1] == 7'h31)
    |=> o_reg_rdata == $past(i_reg_wdata, 3)) else $error("high readback");
  // ***************************************************************
  // match side
  // ***************************************************************
  // match follows frame end
  chk_p2_after_eof: assert property (o_pat2_match |-> $past(i_rx_valid && i_rx_eof))
    else $error("pat2 match");
  chk_p3_after_eof: assert property (o_pat3_match |-> $past(i_rx_valid && i_rx_eof))
    else $error("pat3 match");
  // main scenarios reached
  cov_p2: cover property (o_pat2_match);
  cov_p3: cover property (o_pat3_match);
  cov_hole: cover property (i_reg_rd && !o_reg_hit);
endmodule : wkp_regs_checker

/* verif/tb.sv */
// testbench: register access and wake pattern match checks of the bank
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_sys_clk = 1'b0, i_nrst = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic        i_rx_valid = 1'b0, i_rx_sof = 1'b0, i_rx_eof = 1'b0;
  logic [7:0]  i_reg_addr = 8'h00, i_rx_data = 8'h00;
  logic [1:0]  i_reg_be = 2'h0;
  logic [15:0] i_reg_wdata = 16'h0000, i_pat2_mask_b1_16 = 16'h0000, o_reg_rdata;
  logic        o_reg_rvalid, o_reg_hit, o_pat2_match, o_pat3_match;
  logic [15:0] sh [11];
  logic [7:0]  at [11] = '{8'h50, 8'h52, 8'h56, 8'h58, 8'h5a, 8'h60, 8'h62, 8'h64, 8'h66,
                           8'h68, 8'h6a};
  logic [31:0] c;
  int          failures = 0;
  int          check_count = 0;

  // 250 MHz core clock
  always #2 i_sys_clk = ~i_sys_clk;

  wkp_regs u_wkp_regs (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_be(i_reg_be), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_reg_hit(o_reg_hit),
    .i_pat2_mask_b1_16(i_pat2_mask_b1_16), .i_rx_valid(i_rx_valid), .i_rx_sof(i_rx_sof),
    .i_rx_eof(i_rx_eof), .i_rx_data(i_rx_data), .o_pat2_match(o_pat2_match),
    .o_pat3_match(o_pat3_match));

  // ***************************************************************
  // helpers
  // ***************************************************************
  task automatic stop_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // frame byte k, varied so a mask slip changes the crc
  function automatic logic [7:0] bval(input int k);
    return 8'(k * 29 + 53);
  endfunction : bval

  // mask window of a pattern, byte k on bit k-1
  function automatic logic [63:0] msk(input int p);
    return p ? {sh[10], sh[9], sh[8], sh[7]} : {sh[4], sh[3], sh[2], i_pat2_mask_b1_16};
  endfunction : msk

  // own bitwise crc; only the first 64 bytes can ever count
  function automatic logic [31:0] fcs(input logic [63:0] m);
    logic [31:0] r;
    r = 32'hffffffff;
    for (int k = 1; k <= 64; k++) begin
      if (m[k-1]) begin
        r = r ^ {24'h000000, bval(k)};
        for (int b = 0; b < 8; b++) begin
          r = r[0] ? (r >> 1) ^ 32'hedb88320 : r >> 1;
        end
      end
    end
    return ~r;
  endfunction : fcs

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] e);
    @(negedge i_sys_clk);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_be = e;
    i_reg_wr = 1'b1;
    @(negedge i_sys_clk);
    i_reg_wr = 1'b0;
  endtask : wr

  task automatic wreg(input int i, input logic [15:0] d);
    wr(at[i], d, 2'h3);
    sh[i] = d;
  endtask : wreg

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    logic h;
    // expected decode flag: only the eleven bank words answer
    h = 1'b0;
    foreach (at[i]) h |= (at[i] == {a[7:1], 1'b0});
    @(negedge i_sys_clk);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    // hit is combinational, look once it has settled, well before the edge
    #1;
    chk({15'h0000, o_reg_hit}, {15'h0000, h}, "hit");
    @(negedge i_sys_clk);
    i_reg_rd = 1'b0;
    chk({15'h0000, o_reg_rvalid}, 16'h0001, "rvalid");
    chk(o_reg_rdata, exp, "rdata");
  endtask : rd

  // frame of n bytes, match pulse looked at one cycle after the last byte
  task automatic frame(input int n);
    logic e2, e3;
    e2 = (msk(0) != 64'h0) && (fcs(msk(0)) == {sh[1], sh[0]});
    e3 = (msk(1) != 64'h0) && (fcs(msk(1)) == {sh[6], sh[5]});
    for (int k = 1; k <= n; k++) begin
      @(negedge i_sys_clk);
      i_rx_valid = 1'b1;
      i_rx_sof = (k == 1);
      i_rx_eof = (k == n);
      i_rx_data = bval(k);
    end
    @(negedge i_sys_clk);
    i_rx_valid = 1'b0;
    chk({14'h0000, o_pat2_match, o_pat3_match}, {14'h0000, e2, e3}, "match");
  endtask : frame

  task automatic do_reset();
    @(negedge i_sys_clk);
    i_nrst = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    i_nrst = 1'b1;
    repeat (3) @(negedge i_sys_clk);
    foreach (sh[i]) sh[i] = 16'h0000;
  endtask : do_reset

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    do_reset();
    foreach (at[i]) rd(at[i], 16'h0000);
    foreach (at[i]) wreg(i, {at[i], ~at[i]});
    foreach (at[i]) rd(at[i], sh[i]);
    wr(8'h61, 16'hbeef, 2'h1);
    sh[5][7:0] = 8'hef;
    rd(8'h60, sh[5]);
    wr(8'h5c, 16'hffff, 2'h3);
    rd(8'h5c, 16'h0000);
    foreach (at[i]) wreg(i, 16'h0000);
    frame(20);
    // edge bits of each mask word, frame longer than the window
    for (int p = 0; p < 2; p++) begin
      for (int j = 0; j < 4; j++) begin
        if (p == 0 && j == 0) i_pat2_mask_b1_16 = 16'h8001;
        else wreg(p ? 7 + j : 1 + j, 16'h8001);
        c = fcs(msk(p));
        wreg(p ? 5 : 0, c[15:0]);
        wreg(p ? 6 : 1, c[31:16]);
        frame(70);
        wreg(p ? 6 : 1, ~c[31:16]);
        frame(70);
        if (p == 0 && j == 0) i_pat2_mask_b1_16 = 16'h0000;
        else wreg(p ? 7 + j : 1 + j, 16'h0000);
      end
    end
    // write then read one idle cycle later, as the checker's readback property expects
    wr(8'h62, 16'h5a3c, 2'h3);
    rd(8'h62, 16'h5a3c);
    wreg(1, 16'h1234);
    do_reset();
    rd(8'h52, 16'h0000);
    stop_test();
  end

  // hang guard
  initial begin
    #200000;
    failures++;
    stop_test();
  end
endmodule : tb

bind wkp_regs wkp_regs_checker u_wkp_regs_checker (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
  .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_be(i_reg_be),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
  .o_reg_hit(o_reg_hit), .i_rx_valid(i_rx_valid), .i_rx_eof(i_rx_eof),
  .o_pat2_match(o_pat2_match), .o_pat3_match(o_pat3_match));
